/* rtl/fdi_pkg.sv */
// shared constants, encodings and carriers for the floppy drive interface
package fdi_pkg;

  // ---------------------------------------------------------------
  // clock and precompensation timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STAGE_NS      = 125;
  localparam int unsigned TAP_MID_NS    = 250;
  localparam int unsigned TAP_LONG_NS   = 500;
  localparam int unsigned TAP_ZERO_IDX  = 0;
  localparam int unsigned TAP_MID_IDX   = TAP_MID_NS / STAGE_NS;
  localparam int unsigned TAP_LONG_IDX  = TAP_LONG_NS / STAGE_NS;
  localparam int unsigned SHREG_W       = 8;
  localparam int unsigned ACC_W         = 8;
  localparam logic [ACC_W-1:0] ACC_RST  = 8'h00;

  // ---------------------------------------------------------------
  // drive side timing
  // ---------------------------------------------------------------
  localparam longint unsigned MOTOR_HOLD_MS  = 3000;
  localparam longint unsigned MOTOR_HOLD_CYC =
    MOTOR_HOLD_MS * 64'd1000000 / CLK_PERIOD_NS;
  localparam int unsigned HOLD_W     = 32;
  localparam int unsigned TRACK_W    = 7;
  localparam int unsigned NUM_TRACKS = 80;
  localparam int unsigned NUM_DRIVES = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [SHREG_W-1:0]    SHREG_RST = 8'h00;
  localparam logic [TRACK_W-1:0]    TRACK_RST = 7'h00;
  localparam logic [HOLD_W-1:0]     HOLD_RST  = 32'h0000_0000;
  localparam logic [NUM_DRIVES-1:0] PICK_RST  = 4'hF;

  // ---------------------------------------------------------------
  // encodings and carriers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TAP_EARLY = 3'b001,
    TAP_NOM   = 3'b010,
    TAP_LATE  = 3'b100
  } tap_sel_e;

  typedef struct packed {
    logic precomp_dir_bit1;  // late
    logic precomp_dir_bit0;  // early
  } precomp_dir_s;

  typedef struct packed {
    logic unit_code_bit1_n;
    logic unit_code_bit0_n;
  } unit_code_s;

  // shared controller pins: dual-function outputs of the controller
  typedef struct packed {
    logic lct_dir;   // low current in r/w, direction (high = out) in seek
    logic fr_step_n; // fault reset in r/w, step (active low) in seek
  } ctl_shared_s;

  // drive status lines, all active low
  typedef struct packed {
    logic media_locked_n;
    logic at_outer_track_n;
    logic fault_n;
    logic two_side_n;
  } drv_sense_s;

endpackage : fdi_pkg

/* rtl/stage_tick.sv */
// fractional divider giving one shift tick per stage period
`timescale 1ns/100ps
module stage_tick #(
  parameter int unsigned PERIOD_NS = fdi_pkg::STAGE_NS,
  parameter int unsigned CLK_NS    = fdi_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // tick
  output logic      o_tick
);

  typedef struct packed {
    logic [fdi_pkg::ACC_W-1:0] acc;
    logic                      tick;
  } tick_state_s;

  localparam logic [fdi_pkg::ACC_W-1:0] STEP_V = fdi_pkg::ACC_W'(CLK_NS);
  localparam logic [fdi_pkg::ACC_W-1:0] PER_V  = fdi_pkg::ACC_W'(PERIOD_NS);

  tick_state_s st_reg;
  tick_state_s st_next;
  logic [fdi_pkg::ACC_W-1:0] sum;

  // ---------------------------------------------------------------
  // accumulate clock time, wrap on each stage period
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    sum     = st_reg.acc + STEP_V;
    if (sum >= PER_V) begin
      st_next.acc  = sum - PER_V;
      st_next.tick = 1'b1;
    end else begin
      st_next.acc  = sum;
      st_next.tick = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_reg <= '{acc: fdi_pkg::ACC_RST, tick: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;

endmodule // stage_tick

/* rtl/floppy_drive_interface_precomp.sv */
// floppy drive interface: write precomp, drive select, control mux
`timescale 1ns/100ps
module floppy_drive_interface_precomp #(
  parameter int unsigned                    STRAP          = 0,
  parameter logic [fdi_pkg::HOLD_W-1:0]     MOTOR_HOLD_CYC =
    fdi_pkg::HOLD_W'(fdi_pkg::MOTOR_HOLD_CYC),
  parameter logic [fdi_pkg::TRACK_W-1:0]    LAST_TRACK     =
    fdi_pkg::TRACK_W'(fdi_pkg::NUM_TRACKS - 1)
) (
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  // controller write path
  input  wire logic                         i_wdata,
  input  wire logic                         i_wgate_n,
  input  wire fdi_pkg::precomp_dir_s        i_precomp,
  // controller drive selection and mode
  input  wire fdi_pkg::unit_code_s          i_unit_code,
  input  wire logic                         i_rw_seek,
  input  wire fdi_pkg::ctl_shared_s         i_ctl_shared,
  input  wire logic                         i_motor_on_n,
  input  wire logic                         i_side_sel,
  // drive status lines
  input  wire fdi_pkg::drv_sense_s          i_drv_sense,
  // drive side outputs
  output logic                              o_wdata_n,
  output logic [fdi_pkg::NUM_DRIVES-1:0]    o_drive_pick_n,
  output logic                              o_dir,
  output logic                              o_step_n,
  // controller sense returns
  output logic                              o_sense_a_n,
  output logic                              o_sense_b_n,
  // status
  output logic                              o_media_locked,
  output logic                              o_outer_track_flag,
  output logic [fdi_pkg::TRACK_W-1:0]       o_track_pos,
  output logic                              o_spindle_run,
  output logic                              o_head_side1
);

  typedef struct packed {
    logic [fdi_pkg::SHREG_W-1:0]    shreg;
    fdi_pkg::tap_sel_e              tap_sel;
    logic                           wdata_n;
    logic [fdi_pkg::NUM_DRIVES-1:0] pick_n;
    logic                           dir;
    logic                           step_n;
    logic                           sense_a_n;
    logic                           sense_b_n;
    logic                           media_locked;
    logic                           outer_track;
    logic [fdi_pkg::TRACK_W-1:0]    track;
    logic [fdi_pkg::HOLD_W-1:0]     hold_cnt;
    logic                           spindle;
    logic                           head_side1;
  } state_s;

  localparam state_s ST_RST = '{
    shreg:        fdi_pkg::SHREG_RST,
    tap_sel:      fdi_pkg::TAP_NOM,
    wdata_n:      1'b1,
    pick_n:       fdi_pkg::PICK_RST,
    dir:          1'b1,
    step_n:       1'b1,
    sense_a_n:    1'b1,
    sense_b_n:    1'b1,
    media_locked: 1'b0,
    outer_track:  1'b0,
    track:        fdi_pkg::TRACK_RST,
    hold_cnt:     fdi_pkg::HOLD_RST,
    spindle:      1'b0,
    head_side1:   1'b0
  };

  localparam logic [fdi_pkg::HOLD_W-1:0]  HOLD_ONE  = 32'h0000_0001;
  localparam logic [fdi_pkg::TRACK_W-1:0] TRACK_ONE = 7'h01;
  localparam logic [fdi_pkg::NUM_DRIVES-1:0] PICK_ONE = 4'h1;

  state_s st_reg;
  state_s st_next;
  logic   tick;
  logic   tap;
  logic   selected;
  logic [1:0] unit_idx;

  // ---------------------------------------------------------------
  // stage timing
  // ---------------------------------------------------------------
  stage_tick #(
    .PERIOD_NS (fdi_pkg::STAGE_NS),
    .CLK_NS    (fdi_pkg::CLK_PERIOD_NS)
  ) u_tick (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_tick  (tick)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next  = st_reg;
    unit_idx = ~{i_unit_code.unit_code_bit1_n, i_unit_code.unit_code_bit0_n};
    selected = (unit_idx == 2'(STRAP));

    // precompensation shift register
    if (tick) begin
      st_next.shreg = {st_reg.shreg[fdi_pkg::SHREG_W-2:0], i_wdata};
    end

    // direction choice from the two controller outputs
    unique case ({i_precomp.precomp_dir_bit1, i_precomp.precomp_dir_bit0})
      2'b01:   st_next.tap_sel = fdi_pkg::TAP_EARLY;
      2'b10:   st_next.tap_sel = fdi_pkg::TAP_LATE;
      default: st_next.tap_sel = fdi_pkg::TAP_NOM;
    endcase

    unique case (st_reg.tap_sel)
      fdi_pkg::TAP_EARLY: tap = st_reg.shreg[fdi_pkg::TAP_ZERO_IDX];
      fdi_pkg::TAP_NOM:   tap = st_reg.shreg[fdi_pkg::TAP_MID_IDX];
      fdi_pkg::TAP_LATE:  tap = st_reg.shreg[fdi_pkg::TAP_LONG_IDX];
      default:            tap = st_reg.shreg[fdi_pkg::TAP_MID_IDX];
    endcase
    st_next.wdata_n = i_wgate_n ? 1'b1 : ~tap;

    // drive select decode
    st_next.pick_n = ~(PICK_ONE << unit_idx);

    // shared pin steering; seek lines idle in r/w mode
    if (i_rw_seek) begin
      st_next.dir       = i_ctl_shared.lct_dir;
      st_next.step_n    = i_ctl_shared.fr_step_n;
      st_next.sense_a_n = selected ? i_drv_sense.at_outer_track_n : 1'b1;
      st_next.sense_b_n = selected ? i_drv_sense.two_side_n : 1'b1;
    end else begin
      st_next.dir       = st_reg.dir;
      st_next.step_n    = 1'b1;
      st_next.sense_a_n = selected ? i_drv_sense.fault_n : 1'b1;
      st_next.sense_b_n = selected ? i_drv_sense.media_locked_n : 1'b1;
    end

    // status lines gated by this drive's select
    st_next.media_locked = selected & ~i_drv_sense.media_locked_n;
    st_next.outer_track  = selected & ~i_drv_sense.at_outer_track_n;

    // head motion on the trailing (rising) edge of step
    if (selected && !st_reg.step_n && st_next.step_n) begin
      if (st_next.dir) begin
        if (st_reg.track != fdi_pkg::TRACK_RST) begin
          st_next.track = st_reg.track - TRACK_ONE;
        end
      end else if (st_reg.track != LAST_TRACK) begin
        st_next.track = st_reg.track + TRACK_ONE;
      end
    end

    // side select: high chooses side 0
    if (selected) begin
      st_next.head_side1 = ~i_side_sel;
    end

    // spindle with run-on after motor-on release
    if (!i_motor_on_n) begin
      st_next.hold_cnt = MOTOR_HOLD_CYC;
      st_next.spindle  = 1'b1;
    end else if (st_reg.hold_cnt != fdi_pkg::HOLD_RST) begin
      st_next.hold_cnt = st_reg.hold_cnt - HOLD_ONE;
      st_next.spindle  = 1'b1;
    end else begin
      st_next.spindle  = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_wdata_n          = st_reg.wdata_n;
  assign o_drive_pick_n     = st_reg.pick_n;
  assign o_dir              = st_reg.dir;
  assign o_step_n           = st_reg.step_n;
  assign o_sense_a_n        = st_reg.sense_a_n;
  assign o_sense_b_n        = st_reg.sense_b_n;
  assign o_media_locked     = st_reg.media_locked;
  assign o_outer_track_flag = st_reg.outer_track;
  assign o_track_pos        = st_reg.track;
  assign o_spindle_run      = st_reg.spindle;
  assign o_head_side1       = st_reg.head_side1;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // cycles since the last shift tick, for the period check
  localparam int unsigned GAP_MIN = fdi_pkg::STAGE_NS / fdi_pkg::CLK_PERIOD_NS - 1;
  localparam int unsigned GAP_MAX = GAP_MIN + 1;
  localparam logic [3:0]  GAP_ONE = 4'h1;
  localparam logic [3:0]  GAP_TOP = 4'hF;
  logic [3:0] tick_gap;
  logic       tick_seen;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_gap  <= 4'h0;
      tick_seen <= 1'b0;
    end else if (tick) begin
      tick_gap  <= 4'h0;
      tick_seen <= 1'b1;
    end else if (tick_gap != GAP_TOP) begin
      tick_gap <= tick_gap + GAP_ONE;
    end
  end

  property p_stage_period;
    tick_seen |-> (tick ? (tick_gap >= GAP_MIN && tick_gap <= GAP_MAX)
                        : (tick_gap < GAP_MAX));
  endproperty
  a_stage_period: assert property (p_stage_period)
    else $error("shift tick spacing not 12 or 13 cycles");

  property p_shift_in;
    tick |=> (st_reg.shreg[fdi_pkg::TAP_ZERO_IDX] == $past(i_wdata))
         && (st_reg.shreg[fdi_pkg::TAP_LONG_IDX]
             == $past(st_reg.shreg[fdi_pkg::TAP_LONG_IDX - 1]));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("shift register did not advance on tick");

  property p_late_tap;
    (!i_wgate_n && st_reg.tap_sel == fdi_pkg::TAP_LATE)
      |=> o_wdata_n == !$past(st_reg.shreg[fdi_pkg::TAP_LONG_IDX]);
  endproperty
  a_late_tap: assert property (p_late_tap)
    else $error("late precomp did not use inverted 500 ns tap");

  property p_early_tap;
    (!i_wgate_n && st_reg.tap_sel == fdi_pkg::TAP_EARLY)
      |=> o_wdata_n == !$past(st_reg.shreg[fdi_pkg::TAP_ZERO_IDX]);
  endproperty
  a_early_tap: assert property (p_early_tap)
    else $error("early precomp did not use inverted zero tap");

  property p_dir_choice;
    (i_precomp.precomp_dir_bit0 ^ i_precomp.precomp_dir_bit1) ##1 $stable(i_precomp)
      |-> st_reg.tap_sel == (i_precomp.precomp_dir_bit0 ? fdi_pkg::TAP_EARLY
                                                         : fdi_pkg::TAP_LATE);
  endproperty
  a_dir_choice: assert property (p_dir_choice)
    else $error("tap choice does not follow precomp outputs");

  property p_nominal;
    (i_precomp.precomp_dir_bit0 == i_precomp.precomp_dir_bit1)
      |=> st_reg.tap_sel == fdi_pkg::TAP_NOM;
  endproperty
  a_nominal: assert property (p_nominal)
    else $error("neither or both precomp outputs did not give nominal");

  property p_decode;
    1'b1 |=> $onehot(~o_drive_pick_n) && !o_drive_pick_n[$past(unit_idx)];
  endproperty
  a_decode: assert property (p_decode)
    else $error("drive select decode wrong");

  property p_steer;
    !i_rw_seek |=> o_step_n && (o_sense_b_n == ($past(selected)
                   ? $past(i_drv_sense.media_locked_n) : 1'b1));
  endproperty
  a_steer: assert property (p_steer)
    else $error("shared pins not steered to read/write signals");

  property p_step_out;
    (selected && !st_reg.step_n && st_next.step_n && st_next.dir
      && st_reg.track != fdi_pkg::TRACK_RST)
      |=> o_track_pos == $past(st_reg.track) - TRACK_ONE;
  endproperty
  a_step_out: assert property (p_step_out)
    else $error("outward step did not move one track");

  // track updates on the same edge at which step rises
  property p_no_move;
    $stable(o_step_n) |-> $stable(o_track_pos);
  endproperty
  a_no_move: assert property (p_no_move)
    else $error("track moved without a step edge");

  property p_run_on;
    $rose(i_motor_on_n) |-> o_spindle_run [*8];
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("spindle stopped right after motor-on release");

  property p_wgate_idle;
    i_wgate_n |=> o_wdata_n;
  endproperty
  a_wgate_idle: assert property (p_wgate_idle)
    else $error("write data active while write gate inactive");

  property p_locked;
    1'b1 |=> o_media_locked == ($past(selected) && !$past(i_drv_sense.media_locked_n));
  endproperty
  a_locked: assert property (p_locked)
    else $error("write protect flag wrong");

  property p_side;
    selected |=> o_head_side1 == !$past(i_side_sel);
  endproperty
  a_side: assert property (p_side)
    else $error("side select level mapped wrong");

endmodule // floppy_drive_interface_precomp

/* tb/floppy_drive_model.sv */
// behavioural floppy drive: head position and status lines
`timescale 1ns/100ps
module floppy_drive_model #(
  parameter int START_TRACK = 3
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // drive control lines
  input  wire logic          i_step_n,
  input  wire logic          i_dir,
  input  wire logic          i_pick_n,
  input  wire logic          i_locked,
  // drive status lines
  output fdi_pkg::drv_sense_s o_sense
);
  int   track_reg;
  logic step_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      track_reg <= START_TRACK;
      step_reg  <= 1'b1;
    end else begin
      step_reg <= i_step_n;
      // move only on the trailing edge, only while picked
      if (!i_pick_n && !step_reg && i_step_n) begin
        track_reg <= i_dir ? ((track_reg > 0) ? track_reg - 1 : 0) : track_reg + 1;
      end
    end
  end

  // status lines; only track zero and write protect vary
  assign o_sense = '{media_locked_n:   ~i_locked,
                     at_outer_track_n: (track_reg != 0),
                     fault_n:          1'b1,
                     two_side_n:       1'b0};
endmodule // floppy_drive_model

/* tb/test_floppy_drive_interface_precomp.sv */
// self-checking bench for the floppy drive interface block
`timescale 1ns/100ps
module test_floppy_drive_interface_precomp;
  localparam logic [31:0] HOLD = 32'h0000_0032;
  localparam int          STG_CYC = fdi_pkg::STAGE_NS / fdi_pkg::CLK_PERIOD_NS;

  logic                                i_clk;
  logic                                i_rst_n;
  logic                                i_wdata;
  logic                                i_wgate_n;
  fdi_pkg::precomp_dir_s               i_precomp;
  fdi_pkg::unit_code_s                 i_unit_code;
  logic                                i_rw_seek;
  fdi_pkg::ctl_shared_s                i_ctl_shared;
  logic                                i_motor_on_n;
  logic                                i_side_sel;
  fdi_pkg::drv_sense_s                 i_drv_sense;
  logic                                locked;
  logic                                o_wdata_n;
  logic [fdi_pkg::NUM_DRIVES-1:0]      o_drive_pick_n;
  logic                                o_dir;
  logic                                o_step_n;
  logic                                o_sense_a_n;
  logic                                o_sense_b_n;
  logic                                o_media_locked;
  logic                                o_outer_track_flag;
  logic [fdi_pkg::TRACK_W-1:0]         o_track_pos;
  logic                                o_spindle_run;
  logic                                o_head_side1;
  int                                  n_fail;
  int                                  samples_checked;
  int                                  steps;

  floppy_drive_interface_precomp #(.MOTOR_HOLD_CYC(HOLD)) u_floppy_drive_interface_precomp (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wdata(i_wdata), .i_wgate_n(i_wgate_n),
    .i_precomp(i_precomp), .i_unit_code(i_unit_code), .i_rw_seek(i_rw_seek),
    .i_ctl_shared(i_ctl_shared), .i_motor_on_n(i_motor_on_n), .i_side_sel(i_side_sel),
    .i_drv_sense(i_drv_sense), .o_wdata_n(o_wdata_n), .o_drive_pick_n(o_drive_pick_n),
    .o_dir(o_dir), .o_step_n(o_step_n), .o_sense_a_n(o_sense_a_n),
    .o_sense_b_n(o_sense_b_n), .o_media_locked(o_media_locked),
    .o_outer_track_flag(o_outer_track_flag), .o_track_pos(o_track_pos),
    .o_spindle_run(o_spindle_run), .o_head_side1(o_head_side1));

  floppy_drive_model u_floppy_drive_model (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_step_n(o_step_n), .i_dir(o_dir),
    .i_pick_n(o_drive_pick_n[0]), .i_locked(locked), .o_sense(i_drv_sense));

  always #5 i_clk = ~i_clk;

  // -----------------------------------------------------------------
  // access tasks
  // -----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic step_once(input logic dir);
    i_rw_seek = 1'b1;
    i_ctl_shared = '{lct_dir: dir, fr_step_n: 1'b0};
    tick(3);
    check("step_n low", 32'h0, o_step_n);
    check("dir", {31'h0, dir}, o_dir);
    i_ctl_shared.fr_step_n = 1'b1;
    tick(3);
  endtask

  // latency from data rising to drive data falling; idx is the tap's stage count
  // capture waits up to one stage, each stage is 12 or 13 clocks, output adds one
  task automatic precomp_delay(input logic [1:0] code, input int idx);
    int n;
    int lo;
    int hi;
    lo = idx * STG_CYC + 2;
    hi = (idx + 1) * (STG_CYC + 1) + 1;
    i_wdata = 1'b0;
    i_precomp = code;
    tick(120);
    i_wdata = 1'b1;
    n = 0;
    while (o_wdata_n !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    samples_checked++;
    if (n < lo || n > hi) begin
      n_fail++;
      $display("unexpected precomp delay %0b: expected %0d..%0d, seen %0d",
               code, lo, hi, n);
    end
    i_wdata = 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // watchdog
  // -----------------------------------------------------------------
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end

  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    i_clk = 1'b0; i_rst_n = 1'b0; i_wdata = 1'b0;
    i_wgate_n = 1'b1;
    i_precomp = 2'b00; i_unit_code = 2'b11; i_rw_seek = 1'b0;
    i_ctl_shared = 2'b11; i_motor_on_n = 1'b1; i_side_sel = 1'b1; locked = 1'b0;
    n_fail = 0; samples_checked = 0;
    tick(4);
    check("reset wdata_n", 32'h1, o_wdata_n);
    check("reset pick_n", 32'hF, o_drive_pick_n);
    check("reset step_n", 32'h1, o_step_n);
    i_rst_n = 1'b1;
    tick(2);
    end_test("reset");

    for (int k = 0; k < 4; k++) begin
      i_unit_code = ~k[1:0];
      tick(2);
      check("drive pick", {28'h0, ~(4'h1 << k)}, o_drive_pick_n);
    end
    i_unit_code = 2'b11;
    end_test("select");

    i_wdata = 1'b1;
    tick(120);
    check("wdata_n with gate off", 32'h1, o_wdata_n);
    i_wgate_n = 1'b0;
    precomp_delay(2'b01, 0);
    precomp_delay(2'b00, 2);
    precomp_delay(2'b10, 4);
    precomp_delay(2'b11, 2);
    i_wgate_n = 1'b1;
    tick(3);
    check("wdata_n gate released", 32'h1, o_wdata_n);
    end_test("precomp");

    steps = 0;
    while (o_outer_track_flag !== 1'b1 && steps < 10) begin
      step_once(1'b1);
      steps++;
    end
    check("recalibrate steps", 32'h3, steps);
    check("track at zero", 32'h0, o_track_pos);
    check("seek sense a", 32'h0, o_sense_a_n);
    check("seek sense b", 32'h0, o_sense_b_n);
    step_once(1'b0);
    step_once(1'b0);
    check("track after step in", 32'h2, o_track_pos);
    check("outer flag cleared", 32'h0, o_outer_track_flag);
    step_once(1'b1);
    check("track after step out", 32'h1, o_track_pos);
    end_test("seek");

    i_unit_code = 2'b10;
    tick(2);
    check("unselected sense a", 32'h1, o_sense_a_n);
    step_once(1'b0);
    check("track unselected", 32'h1, o_track_pos);
    i_unit_code = 2'b11;
    i_rw_seek = 1'b0;
    i_ctl_shared = 2'b00;
    locked = 1'b1;
    tick(3);
    check("rw step_n idle", 32'h1, o_step_n);
    check("rw sense a", 32'h1, o_sense_a_n);
    check("rw sense b", 32'h0, o_sense_b_n);
    check("media locked", 32'h1, o_media_locked);
    i_side_sel = 1'b0;
    tick(2);
    check("side 1 head", 32'h1, o_head_side1);
    i_side_sel = 1'b1;
    tick(2);
    check("side 0 head", 32'h0, o_head_side1);
    end_test("steering");

    i_motor_on_n = 1'b0;
    tick(3);
    check("spindle on", 32'h1, o_spindle_run);
    i_motor_on_n = 1'b1;
    tick(HOLD - 5);
    check("spindle held", 32'h1, o_spindle_run);
    tick(10);
    check("spindle stopped", 32'h0, o_spindle_run);
    end_test("motor");
    finish_test();
  end
endmodule // test_floppy_drive_interface_precomp
